// ===== inc/fede_params.svh
`ifndef FEDE_PARAMS_SVH
`define FEDE_PARAMS_SVH

// register byte offsets
`define FEDE_OFS_CTRL 8'h00
`define FEDE_OFS_PERIOD 8'h04
`define FEDE_OFS_DUTY 8'h08
`define FEDE_OFS_CMPB 8'h0c
`define FEDE_OFS_STATUS 8'h10

// control fields
`define FEDE_CTRL_ENABLE 0
`define FEDE_CTRL_DOWN 1
`define FEDE_CTRL_EDGE_LO 2
`define FEDE_CTRL_SHADOW 4
`define FEDE_CTRL_LOAD_PRD 5
`define FEDE_CTRL_DIAG 6
`define FEDE_CTRL_HPE 7
`define FEDE_CTRL_RESET 8'h00
`define FEDE_PERIOD_RESET 16'hffff

// fine step byte inside the extension half-word
`define FEDE_FINE_LO 8

// cycles with fine positioning unavailable
`define FEDE_BLANK_NORMAL 3'h3
`define FEDE_BLANK_DIAG 3'h6

`define FEDE_RESP_OKAY 2'h0
`define FEDE_RESP_SLVERR 2'h2

`endif

// ===== inc/fede_pkg.sv
package fede_pkg;

    typedef enum logic [1:0] {
        FEDE_EDGE_OFF = 2'h0,
        FEDE_EDGE_RISE = 2'h1,
        FEDE_EDGE_FALL = 2'h2,
        FEDE_EDGE_BOTH = 2'h3
    } fede_edge_t;

    // coarse count in the high half, fine extension in the low half
    typedef struct packed {
        logic [15:0] coarse;
        logic [15:0] ext;
    } fede_cmp_t;

    typedef struct packed {
        logic pwm_a;
        logic pwm_b;
        logic [7:0] fine_step;
        logic fine_rise;
        logic fine_fall;
    } fede_pwm_out_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ctrl;
        logic [15:0] period;
        fede_cmp_t duty_sh;
        fede_cmp_t duty_act;
        logic [15:0] cmpb_sh;
        logic [15:0] cmpb_act;
        logic [15:0] cnt;
        logic [2:0] age;
        fede_pwm_out_t out;
    } fede_state_t;

endpackage

// ===== hdl/fede_top.sv
// Function
// - duty edge sits at the coarse count, then delayed by the fine steps.
// - only the extension's upper byte counts, its low byte is ignored.
// - coarse count and extension share one word, loaded by one 32-bit write.
// - no diagnostics: fine positioning is off the first 3 cycles of a period.
// - diagnostics running: fine positioning is off the first 6 cycles.
// - coarse duty control keeps working in those cycles, down to 0% duty when counting up.
// - down count, rise mode, hires period off: blank moves to period end.
// - fine positioning applies to rising, falling or both edges by mode.
// - the fine extension is shadowed with the same load event as coarse.
// - the fine stage resolves one clock period into 256 steps.
// - only channel A gets the fine step, channel B stays coarse.
`timescale 1ns/1ps
`default_nettype none
`include "fede_params.svh"

module fede_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output fede_pkg::fede_pwm_out_t pwm_out
);

    fede_pkg::fede_state_t q;
    fede_pkg::fede_state_t d;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == `FEDE_OFS_CTRL || a == `FEDE_OFS_PERIOD ||
               a == `FEDE_OFS_DUTY || a == `FEDE_OFS_CMPB ||
               a == `FEDE_OFS_STATUS;
    endfunction

    logic enable;
    logic down;
    fede_pkg::fede_edge_t edge_mode;
    logic at_zero;
    logic at_prd;
    logic period_start;
    logic load_now;
    logic [2:0] blank;
    logic fine_open;
    logic rise;
    logic fall;
    logic [7:0] fine_byte;
    logic [31:0] wv;

    always_comb begin
        d = q;
        enable = q.ctrl[`FEDE_CTRL_ENABLE];
        down = q.ctrl[`FEDE_CTRL_DOWN];
        edge_mode = fede_pkg::fede_edge_t'(q.ctrl[`FEDE_CTRL_EDGE_LO +: 2]);
        at_zero = q.cnt == 16'h0000;
        at_prd = q.cnt == q.period;
        wv = 32'h0000_0000;

        // ---- write channel: address and data taken in either order
        if (awvalid && q.awready) begin
            d.waddr = awaddr;
            d.aw_got = 1'b1;
            d.awready = 1'b0;
        end
        if (wvalid && q.wready) begin
            d.wdata = wdata;
            d.wstrb = wstrb;
            d.w_got = 1'b1;
            d.wready = 1'b0;
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
            d.awready = 1'b1;
            d.wready = 1'b1;
        end
        if (q.aw_got && q.w_got && !q.bvalid) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = mapped(q.waddr) ? `FEDE_RESP_OKAY : `FEDE_RESP_SLVERR;
            unique case (q.waddr)
                `FEDE_OFS_CTRL: begin
                    wv = merge({24'h000000, q.ctrl}, q.wdata, q.wstrb);
                    d.ctrl = wv[7:0];
                end
                `FEDE_OFS_PERIOD: begin
                    wv = merge({16'h0000, q.period}, q.wdata, q.wstrb);
                    d.period = wv[15:0];
                end
                `FEDE_OFS_DUTY: begin
                    d.duty_sh = merge(q.duty_sh, q.wdata, q.wstrb);
                end
                `FEDE_OFS_CMPB: begin
                    wv = merge({q.cmpb_sh, 16'h0000}, q.wdata, q.wstrb);
                    d.cmpb_sh = wv[31:16];
                end
                default: begin
                end
            endcase
        end

        // ---- read channel, one outstanding read
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end
        if (arvalid && q.arready) begin
            d.arready = 1'b0;
            d.rvalid = 1'b1;
            d.rresp = mapped(araddr) ? `FEDE_RESP_OKAY : `FEDE_RESP_SLVERR;
            unique case (araddr)
                `FEDE_OFS_CTRL: d.rdata = {24'h000000, q.ctrl};
                `FEDE_OFS_PERIOD: d.rdata = {16'h0000, q.period};
                `FEDE_OFS_DUTY: d.rdata = q.duty_sh;
                `FEDE_OFS_CMPB: d.rdata = {q.cmpb_sh, 16'h0000};
                `FEDE_OFS_STATUS: d.rdata = {11'h000, q.age, q.out.pwm_b,
                                             q.out.pwm_a, q.cnt};
                default: d.rdata = 32'h0000_0000;
            endcase
        end

        // ---- timebase
        period_start = 1'b0;
        if (!enable) begin
            d.cnt = 16'h0000;
        end else if (down) begin
            if (at_zero) begin
                d.cnt = q.period;
                period_start = 1'b1;
            end else begin
                d.cnt = q.cnt - 16'h0001;
            end
        end else begin
            if (q.cnt >= q.period) begin
                d.cnt = 16'h0000;
                period_start = 1'b1;
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
        end
        // parked counter is a period start, else first period is unblanked
        if (!enable || period_start) begin
            d.age = 3'h0;
        end else if (q.age != 3'h7) begin
            d.age = q.age + 3'h1;
        end

        // same load event for coarse and fine
        load_now = !q.ctrl[`FEDE_CTRL_SHADOW] ||
                   (q.ctrl[`FEDE_CTRL_LOAD_PRD] ? at_prd : at_zero);
        if (load_now) begin
            d.duty_act = q.duty_sh;
            d.cmpb_act = q.cmpb_sh;
        end

        // coarse compare, clear beats set on up count so 0% holds, set wins on down count
        if (!enable) begin
            d.out.pwm_a = 1'b0;
            d.out.pwm_b = 1'b0;
        end else if (down) begin
            if (q.cnt == q.duty_act.coarse) begin
                d.out.pwm_a = 1'b1;
            end else if (at_prd) begin
                d.out.pwm_a = 1'b0;
            end
            if (q.cnt == q.cmpb_act) begin
                d.out.pwm_b = 1'b1;
            end else if (at_prd) begin
                d.out.pwm_b = 1'b0;
            end
        end else begin
            if (q.cnt == q.duty_act.coarse) begin
                d.out.pwm_a = 1'b0;
            end else if (at_zero) begin
                d.out.pwm_a = 1'b1;
            end
            if (q.cnt == q.cmpb_act) begin
                d.out.pwm_b = 1'b0;
            end else if (at_zero) begin
                d.out.pwm_b = 1'b1;
            end
        end

        blank = q.ctrl[`FEDE_CTRL_DIAG] ? `FEDE_BLANK_DIAG
                                        : `FEDE_BLANK_NORMAL;
        // blank moves to the last counts before zero
        if (down && edge_mode == fede_pkg::FEDE_EDGE_RISE &&
            !q.ctrl[`FEDE_CTRL_HPE]) begin
            fine_open = q.cnt >= {13'h0000, blank};
        end else begin
            // fine stage waits out the period start
            fine_open = q.age >= blank;
        end

        // low byte never reaches the stepper
        fine_byte = q.duty_act.ext[`FEDE_FINE_LO +: 8];
        rise = !q.out.pwm_a && d.out.pwm_a;
        fall = q.out.pwm_a && !d.out.pwm_a;
        d.out.fine_rise = rise && fine_open &&
            (edge_mode == fede_pkg::FEDE_EDGE_RISE ||
             edge_mode == fede_pkg::FEDE_EDGE_BOTH);
        d.out.fine_fall = fall && fine_open &&
            (edge_mode == fede_pkg::FEDE_EDGE_FALL ||
             edge_mode == fede_pkg::FEDE_EDGE_BOTH);
        // step count goes with channel A edge only
        d.out.fine_step = (d.out.fine_rise || d.out.fine_fall)
                          ? fine_byte : 8'h00;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
            q.ctrl <= `FEDE_CTRL_RESET;
            q.period <= `FEDE_PERIOD_RESET;
        end else begin
            q <= d;
        end
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign pwm_out = q.out;

endmodule

`default_nettype wire

// ===== test/fede_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none

module fede_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire fede_pkg::fede_pwm_out_t pwm_out
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_wr_answer;
        !awready && !wready ##1 bvalid;
    endsequence

    a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
        else $error("write answer late or missing");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late or missing");
    a_bresp_stands: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    a_rdata_stands: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    a_bus_release: assert property (
        bvalid && bready |=> !bvalid && awready && wready)
        else $error("write channel not released");
    a_fall_pairs: assert property (
        pwm_out.fine_fall |-> $fell(pwm_out.pwm_a))
        else $error("fine fall without channel a fall");
    a_rise_pairs: assert property (
        pwm_out.fine_rise |-> $rose(pwm_out.pwm_a))
        else $error("fine rise without channel a rise");
    a_step_idle: assert property (
        !(pwm_out.fine_rise || pwm_out.fine_fall) |->
        pwm_out.fine_step == 8'h00)
        else $error("fine step outside an edge");
    a_pulse_single: assert property (
        pwm_out.fine_fall |=> !pwm_out.fine_fall)
        else $error("fine fall wider than one cycle");
endmodule

`default_nettype wire

// ===== test/fede_stage_model.sv
`timescale 1ns/1ps
`default_nettype none

// power stage side: only listens, measures the last high run of each channel
module fede_stage_model (
    input wire logic aclk,
    input wire fede_pkg::fede_pwm_out_t pwm_out,
    output logic [15:0] high_len,
    output logic [15:0] high_len_b
);
    logic [15:0] run_q = 16'h0000;
    logic [15:0] len_q = 16'h0000;
    logic [15:0] run_b_q = 16'h0000;
    logic [15:0] len_b_q = 16'h0000;

    assign high_len = len_q;
    assign high_len_b = len_b_q;

    always @(posedge aclk) begin
        if (pwm_out.pwm_b === 1'b1) begin
            run_b_q <= run_b_q + 16'h0001;
        end else begin
            if (run_b_q != 16'h0000) begin
                len_b_q <= run_b_q;
            end
            run_b_q <= 16'h0000;
        end
    end

    always @(posedge aclk) begin
        if (pwm_out.pwm_a === 1'b1) begin
            run_q <= run_q + 16'h0001;
        end else begin
            // a run only counts once it has ended
            if (run_q != 16'h0000) begin
                len_q <= run_q;
            end
            run_q <= 16'h0000;
        end
    end
endmodule

`default_nettype wire

// ===== test/fede_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "fede_params.svh"

module fede_top_test;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr, step;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [15:0] high_len, high_len_b;
    fede_pkg::fede_pwm_out_t pwm_out;
    int err_count, compares, cyc, hi, fr, ff;
    // ctrl, coarse, expect rise, expect fall
    logic [31:0] rows [12] = '{32'h09050001, 32'h09020000, 32'h09030001,
        32'h49050000, 32'h49060001, 32'h01050000, 32'h0d050001,
        32'h07020000, 32'h87020002, 32'h07050002, 32'h19020000,
        32'h39050001};

    fede_top u_fede_top (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .pwm_out(pwm_out));
    fede_stage_model u_fede_stage_model (.aclk(aclk), .pwm_out(pwm_out),
        .high_len(high_len), .high_len_b(high_len_b));

    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic complete_run;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1;
                awvalid <= 0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1;
                wvalid <= 0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk("bresp", 32'(bresp), 32'(er));
        bready <= 0;
        @(posedge aclk);
    endtask

    task automatic rdr(input logic [7:0] a, input logic [1:0] er,
                       output logic [31:0] d);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        chk("rresp", 32'(rresp), 32'(er));
        rready <= 0;
        @(posedge aclk);
    endtask

    // the writer packs coarse count and extension word as one
    task automatic run(input logic [7:0] c, input logic [15:0] co,
                       input logic [15:0] ex);
        wr(`FEDE_OFS_CTRL, 32'h0, `FEDE_RESP_OKAY);
        wr(`FEDE_OFS_DUTY, {co, ex}, `FEDE_RESP_OKAY);
        wr(`FEDE_OFS_CTRL, {24'h0, c}, `FEDE_RESP_OKAY);
        hi = 0;
        fr = 0;
        ff = 0;
        step = 8'hff;
        repeat (40) begin
            @(posedge aclk);
            if (pwm_out.fine_rise === 1'b1 || pwm_out.fine_fall === 1'b1)
                step = pwm_out.fine_step;
            hi += int'(pwm_out.pwm_a === 1'b1);
            fr += int'(pwm_out.fine_rise === 1'b1);
            ff += int'(pwm_out.fine_fall === 1'b1);
        end
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            complete_run;
        end
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hf;
        {err_count, compares, cyc} = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rdr(`FEDE_OFS_CTRL, `FEDE_RESP_OKAY, rd);
        chk("ctrl reset", rd, 32'h0);
        rdr(`FEDE_OFS_PERIOD, `FEDE_RESP_OKAY, rd);
        chk("period reset", rd, {16'h0, `FEDE_PERIOD_RESET});
        wr(8'h14, 32'h1, `FEDE_RESP_SLVERR);
        rdr(8'h14, `FEDE_RESP_SLVERR, rd);
        chk("unmapped read", rd, 32'h0);
        wr(`FEDE_OFS_PERIOD, 32'h9, `FEDE_RESP_OKAY);
        rdr(`FEDE_OFS_PERIOD, `FEDE_RESP_OKAY, rd);
        chk("period", rd, 32'h9);
        wr(`FEDE_OFS_CMPB, 32'h0007_0000, `FEDE_RESP_OKAY);
        for (int i = 0; i < 12; i++) begin
            run(rows[i][31:24], {8'h0, rows[i][23:16]}, 16'h1780);
            chk("fine rise", 32'(fr > 0), 32'(rows[i][1]));
            chk("fine fall", 32'(ff > 0), 32'(rows[i][0]));
            if (fr + ff > 0) chk("fine step", 32'(step), 32'h17);
            if (!rows[i][25]) begin
                chk("high time", 32'(high_len), 32'(rows[i][23:16]));
                chk("chan b high", 32'(high_len_b), 32'h7);
            end
            $display("test row %0d done", i);
        end
        run(8'h09, 16'h5, 16'h1980);
        chk("refreshed step", 32'(step), 32'h19);
        run(8'h09, 16'h5, 16'h00c0);
        chk("zero step fall", 32'(ff > 0), 32'h1);
        chk("zero step", 32'(step), 32'h0);
        chk("zero step high", 32'(high_len), 32'h5);
        $display("test fine step done");
        run(8'h09, 16'h0, 16'h1780);
        chk("zero duty", 32'(hi), 32'h0);
        wr(`FEDE_OFS_CTRL, 32'h0, `FEDE_RESP_OKAY);
        rdr(`FEDE_OFS_STATUS, `FEDE_RESP_OKAY, rd);
        chk("idle status", rd, 32'h0);
        $display("test zero duty done");
        complete_run;
    end
endmodule

bind fede_top fede_checker u_fede_checker (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .pwm_out(pwm_out));

`default_nettype wire
